// *** rtl/pmt8_pkg.sv ***
// Package with register map, field layout and reset values of the 8-bit period match timer.
package pmt8_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_PERIOD_COUNTER = 8'h00;
  localparam logic [7:0] ADDR_PERIOD_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h0c;

  // ---------------------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------------------
  localparam int CTL_INDIV_LSB = 0;
  localparam int CTL_RUN_BIT = 2;
  localparam int CTL_MATCHDIV_LSB = 3;
  localparam int STS_FLAG_BIT = 1;
  localparam int STS_ENABLE_BIT = 0;
  localparam logic [7:0] PERIOD_COUNTER_RESET = 8'h00;
  localparam logic [7:0] PERIOD_LIMIT_RESET = 8'hff;
  localparam logic [6:0] CONTROL_RESET = 7'h00;
  localparam logic [3:0] PRESCALE_DIV4_LAST = 4'h3;
  localparam logic [3:0] PRESCALE_DIV16_LAST = 4'hf;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Control fields as software sees them.
  typedef struct packed {
    logic [3:0] match_divider_select;
    logic counter_run;
    logic [1:0] input_divider_select;
  } pmt8_ctl_s;

endpackage : pmt8_pkg

// *** rtl/pmt8_timer.sv ***
// 8-bit period match timer with prescaler, postscaler and AHB-Lite registers.
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps

module pmt8_timer #(
  parameter int TICK_DIV = 4
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic O_MATCH_PULSE,
  output logic O_MATCH_EVENT_FLAG,
  output logic O_MATCH_IRQ
);

  // ---------------------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------------------
  logic ph_valid;
  logic ph_write;
  logic [7:0] ph_addr;
  logic addr_ok;
  logic wr_counter;
  logic wr_limit;
  logic wr_control;
  logic wr_status;

  assign addr_ok = I_HSEL && I_HREADY && (I_HTRANS == pmt8_pkg::HTRANS_NONSEQ);

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      ph_valid <= addr_ok && (I_HSIZE == pmt8_pkg::HSIZE_WORD);
      ph_write <= I_HWRITE;
      ph_addr <= I_HADDR[7:0];
    end
  end

  assign wr_counter = ph_valid && ph_write && (ph_addr == pmt8_pkg::ADDR_PERIOD_COUNTER);
  assign wr_limit = ph_valid && ph_write && (ph_addr == pmt8_pkg::ADDR_PERIOD_LIMIT);
  assign wr_control = ph_valid && ph_write && (ph_addr == pmt8_pkg::ADDR_TIMER_CONTROL);
  assign wr_status = ph_valid && ph_write && (ph_addr == pmt8_pkg::ADDR_EVENT_STATUS);

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end else begin
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [7:0] period_counter;
  logic [7:0] period_limit;
  pmt8_pkg::pmt8_ctl_s timer_control;
  logic match_event_enable;

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      period_limit <= pmt8_pkg::PERIOD_LIMIT_RESET;
    end else if (wr_limit) begin
      period_limit <= I_HWDATA[7:0];
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      timer_control <= pmt8_pkg::CONTROL_RESET;
    end else if (wr_control) begin
      timer_control <= I_HWDATA[6:0];
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      match_event_enable <= 1'b0;
    end else if (wr_status) begin
      match_event_enable <= I_HWDATA[pmt8_pkg::STS_ENABLE_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Instruction tick and prescaler
  // ---------------------------------------------------------------------------
  localparam int TICK_W = $clog2(TICK_DIV);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);
  logic [TICK_W-1:0] tick_cnt;
  logic inst_tick;
  logic [3:0] pre_cnt;
  logic [3:0] pre_last;
  logic count_en;
  logic run;
  logic scaler_clear;

  assign run = timer_control.counter_run;
  assign scaler_clear = wr_counter || wr_control;

  // instruction clock is core clock divided down
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      tick_cnt <= '0;
    end else if (tick_cnt == TICK_LAST) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + TICK_W'(1);
    end
  end
  assign inst_tick = (tick_cnt == TICK_LAST);

  always_comb begin
    case (timer_control.input_divider_select)
      2'b00: pre_last = 4'h0;
      2'b01: pre_last = pmt8_pkg::PRESCALE_DIV4_LAST;
      default: pre_last = pmt8_pkg::PRESCALE_DIV16_LAST;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      pre_cnt <= 4'h0;
    end else if (scaler_clear) begin
      pre_cnt <= 4'h0;
    end else if (run && inst_tick) begin
      pre_cnt <= (pre_cnt >= pre_last) ? 4'h0 : pre_cnt + 4'h1;
    end
  end
  assign count_en = run && inst_tick && (pre_cnt >= pre_last) && !scaler_clear;

  // ---------------------------------------------------------------------------
  // Period counter and comparator
  // ---------------------------------------------------------------------------
  logic match;

  assign match = count_en && (period_counter == period_limit);

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      period_counter <= pmt8_pkg::PERIOD_COUNTER_RESET;
    end else if (wr_counter) begin
      period_counter <= I_HWDATA[7:0];
    end else if (match) begin
      period_counter <= 8'h00;
    end else if (count_en) begin
      period_counter <= period_counter + 8'h01;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_MATCH_PULSE <= 1'b0;
    end else begin
      O_MATCH_PULSE <= match;
    end
  end

  // ---------------------------------------------------------------------------
  // Postscaler and event flag
  // ---------------------------------------------------------------------------
  logic [3:0] post_cnt;
  logic post_done;
  logic flag_clear;

  assign post_done = match && (post_cnt == timer_control.match_divider_select);

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      post_cnt <= 4'h0;
    end else if (scaler_clear) begin
      post_cnt <= 4'h0;
    end else if (post_done) begin
      post_cnt <= 4'h0;
    end else if (match) begin
      post_cnt <= post_cnt + 4'h1;
    end
  end

  assign flag_clear = wr_status && !I_HWDATA[pmt8_pkg::STS_FLAG_BIT];

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_MATCH_EVENT_FLAG <= 1'b0;
      O_MATCH_IRQ <= 1'b0;
    end else begin
      O_MATCH_EVENT_FLAG <= post_done || (O_MATCH_EVENT_FLAG && !flag_clear);
      O_MATCH_IRQ <= (post_done || (O_MATCH_EVENT_FLAG && !flag_clear)) &&
                     (wr_status ? I_HWDATA[pmt8_pkg::STS_ENABLE_BIT] : match_event_enable);
    end
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_HRDATA <= 32'h0000_0000;
    end else if (addr_ok && !I_HWRITE) begin
      case (I_HADDR[7:0])
        pmt8_pkg::ADDR_PERIOD_COUNTER: O_HRDATA <= {24'h000000, period_counter};
        pmt8_pkg::ADDR_PERIOD_LIMIT: O_HRDATA <= {24'h000000, period_limit};
        pmt8_pkg::ADDR_TIMER_CONTROL: O_HRDATA <= {25'h0, timer_control};
        pmt8_pkg::ADDR_EVENT_STATUS: O_HRDATA <= {30'h0, O_MATCH_EVENT_FLAG,
                                                  match_event_enable};
        default: O_HRDATA <= 32'h0000_0000;
      endcase
    end else begin
      O_HRDATA <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence s_match_step;
    count_en && (period_counter == period_limit);
  endsequence

  sequence s_zero_next;
    ##1 period_counter == 8'h00;
  endsequence

  chk_match_reload: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s_match_step |-> s_zero_next)
    else $error("counter not zero after match");

  chk_write_wins: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    wr_counter |=> period_counter == $past(I_HWDATA[7:0]))
    else $error("counter write lost");

  chk_ctl_keeps_cnt: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    wr_control && !count_en |=> $stable(period_counter))
    else $error("control write changed counter");

  chk_stop_holds: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    !run && !wr_counter |=> $stable(period_counter) && !O_MATCH_PULSE)
    else $error("counter moved while stopped");

  chk_scaler_clear: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    scaler_clear |=> pre_cnt == 4'h0 && post_cnt == 4'h0)
    else $error("scalers not cleared");

  chk_match_export: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    match |=> O_MATCH_PULSE)
    else $error("match pulse missing");

  chk_flag_set: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    post_done |=> O_MATCH_EVENT_FLAG)
    else $error("event flag not set");

  chk_ctl_bit7: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    ph_valid && !ph_write && ph_addr == pmt8_pkg::ADDR_TIMER_CONTROL |-> O_HRDATA[7] == 1'b0)
    else $error("control bit 7 read nonzero");

  chk_prescale_div1: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    run && timer_control.input_divider_select == 2'b00 && inst_tick && !scaler_clear
    |-> count_en)
    else $error("divide by one missed a tick");

  chk_count_step: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    count_en && !match && !wr_counter |=> period_counter == $past(period_counter) + 8'h01)
    else $error("counter did not step");

endmodule // pmt8_timer

// *** verification/pmt8_timer_bench.sv ***
// Self-checking testbench for the 8-bit period match timer.
`timescale 1ns/1ps

module pmt8_timer_bench;
  // ---------------------------------------------------------------------------
  // Signals and design instance
  // ---------------------------------------------------------------------------
  localparam int TICK = 4;
  logic clk, rst, hsel, hwrite, hready, hresp, pulse, flag, irq, hr_q;
  logic pulse_q, flag_q, irq_q, hresp_q;
  logic [31:0] haddr, hwdata, hrdata, rd_q, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int n_fail, checks_done;

  pmt8_timer #(.TICK_DIV(TICK)) DUT (.I_CORE_CLK(clk), .I_RST(rst), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
    .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready),
    .O_HRESP(hresp), .O_MATCH_PULSE(pulse), .O_MATCH_EVENT_FLAG(flag), .O_MATCH_IRQ(irq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Design outputs taken mid-cycle, where they are settled for the next rising edge.
  always @(negedge clk) begin
    rd_q <= hrdata;
    hr_q <= hready;
    pulse_q <= pulse;
    flag_q <= flag;
    irq_q <= irq;
    hresp_q <= hresp;
  end

  // ---------------------------------------------------------------------------
  // Helper tasks
  // ---------------------------------------------------------------------------
  task automatic tick();
    @(posedge clk);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= pmt8_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do tick(); while (hr_q !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do tick(); while (hr_q !== 1'b1);
    rd = rd_q;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    check(rd, exp, what);
    check({31'h0, hresp_q}, 32'h0, "okay response");
  endtask

  task automatic wait_pulse(output int n);
    n = 0;
    do begin tick(); n++; end while (pulse_q !== 1'b1);
  endtask

  function automatic int pre(input logic [1:0] code);
    return (code == 2'h0) ? 1 : (code == 2'h1) ? 4 : 16;
  endfunction

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    int n;
    logic [7:0] v, lim;
    logic [31:0] a;
    logic [3:0] codes [3];
    void'($urandom(44));
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = pmt8_pkg::HSIZE_WORD;
    hwdata = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    tick();
    rd_chk(pmt8_pkg::ADDR_PERIOD_COUNTER, 32'h0, "counter reset");
    rd_chk(pmt8_pkg::ADDR_PERIOD_LIMIT, 32'hff, "limit reset");
    rd_chk(pmt8_pkg::ADDR_TIMER_CONTROL, 32'h0, "control reset");
    rd_chk(8'h10, 32'h0, "unmapped read");
    bus(1'b1, pmt8_pkg::ADDR_TIMER_CONTROL, 32'hfb);
    rd_chk(pmt8_pkg::ADDR_TIMER_CONTROL, 32'h7b, "control top bit");
    $display("reset and control test done");
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom());
      lim = 8'($urandom());
      bus(1'b1, pmt8_pkg::ADDR_PERIOD_COUNTER, {24'h0, v});
      bus(1'b1, pmt8_pkg::ADDR_PERIOD_LIMIT, {24'h0, lim});
      rd_chk(pmt8_pkg::ADDR_PERIOD_COUNTER, {24'h0, v}, "counter rw");
      rd_chk(pmt8_pkg::ADDR_PERIOD_LIMIT, {24'h0, lim}, "limit rw");
      bus(1'b1, pmt8_pkg::ADDR_TIMER_CONTROL, {24'h0, 8'($urandom()) & 8'h7b});
      rd_chk(pmt8_pkg::ADDR_PERIOD_COUNTER, {24'h0, v}, "control write keeps count");
    end
    $display("register access test done");
    for (int c = 0; c < 4; c++) begin
      lim = 8'($urandom_range(0, 15));
      bus(1'b1, pmt8_pkg::ADDR_TIMER_CONTROL, 32'h0);
      bus(1'b1, pmt8_pkg::ADDR_PERIOD_LIMIT, {24'h0, lim});
      bus(1'b1, pmt8_pkg::ADDR_PERIOD_COUNTER, 32'h0);
      bus(1'b1, pmt8_pkg::ADDR_TIMER_CONTROL, 32'h4 | 32'(c));
      wait_pulse(n);
      wait_pulse(n);
      check(32'(n), 32'((int'(lim) + 1) * pre(2'(c)) * TICK), "match period");
    end
    $display("prescale and period test done");
    codes[0] = 4'h0;
    codes[1] = 4'hf;
    codes[2] = 4'($urandom());
    foreach (codes[j]) begin
      bus(1'b1, pmt8_pkg::ADDR_TIMER_CONTROL, 32'h0);
      bus(1'b1, pmt8_pkg::ADDR_PERIOD_COUNTER, 32'h0);
      bus(1'b1, pmt8_pkg::ADDR_PERIOD_LIMIT, 32'h2);
      bus(1'b1, pmt8_pkg::ADDR_EVENT_STATUS, 32'h1);
      bus(1'b1, pmt8_pkg::ADDR_TIMER_CONTROL, {25'h0, codes[j], 3'h4});
      for (int k = 1; k <= int'(codes[j]) + 1; k++) begin
        wait_pulse(n);
        tick();
        tick();
        check({31'h0, flag_q}, {31'h0, k == int'(codes[j]) + 1}, "postscaled flag");
      end
      check({31'h0, irq_q}, 32'h1, "enabled request");
    end
    $display("postscale and flag test done");
    bus(1'b1, pmt8_pkg::ADDR_TIMER_CONTROL, 32'h0);
    bus(1'b0, pmt8_pkg::ADDR_PERIOD_COUNTER, 32'h0);
    a = rd;
    n = 0;
    repeat (200) begin
      tick();
      n += int'(pulse_q === 1'b1);
    end
    check(32'(n), 32'h0, "pulses while stopped");
    rd_chk(pmt8_pkg::ADDR_PERIOD_COUNTER, a, "count holds while stopped");
    bus(1'b1, pmt8_pkg::ADDR_EVENT_STATUS, 32'h2);
    rd_chk(pmt8_pkg::ADDR_EVENT_STATUS, 32'h2, "flag kept, enable off");
    check({31'h0, irq_q}, 32'h0, "masked request");
    bus(1'b1, pmt8_pkg::ADDR_EVENT_STATUS, 32'h0);
    tick();
    check({31'h0, flag_q}, 32'h0, "flag cleared");
    $display("stop and mask test done");
    bus(1'b1, pmt8_pkg::ADDR_PERIOD_LIMIT, 32'h80);
    bus(1'b1, pmt8_pkg::ADDR_TIMER_CONTROL, 32'h4);
    repeat (40) tick();
    rst <= 1'b1;
    repeat (3) tick();
    rst <= 1'b0;
    tick();
    rd_chk(pmt8_pkg::ADDR_PERIOD_COUNTER, 32'h0, "counter after reset");
    rd_chk(pmt8_pkg::ADDR_PERIOD_LIMIT, 32'hff, "limit after reset");
    rd_chk(pmt8_pkg::ADDR_TIMER_CONTROL, 32'h0, "control after reset");
    $display("mid-run reset test done");
    finish_test();
  end
endmodule // pmt8_timer_bench
